// file: common/sepc_defs.vh
// constants for the serial prom command controller
`ifndef SEPC_DEFS_VH
`define SEPC_DEFS_VH
// register offsets (byte addresses)
`define SEPC_CMD_OFF 12'h030
`define SEPC_DATA_OFF 12'h034
// command register fields
`define SEPC_BUSY_BIT 31
`define SEPC_CMD_HI 30
`define SEPC_CMD_LO 28
`define SEPC_TMO_BIT 10
`define SEPC_LOADED_BIT 9
`define SEPC_ADDR_HI 8
`define SEPC_ADDR_LO 0
// command codes
`define SEPC_C_READ 3'h0
`define SEPC_C_ERASE_WRITE_DISABLE_CMD 3'h1
`define SEPC_C_ERASE_WRITE_ENABLE_CMD 3'h2
`define SEPC_C_WRITE 3'h3
`define SEPC_C_WRITE_ALL_CMD 3'h4
`define SEPC_C_ERASE 3'h5
`define SEPC_C_ERASE_ALL_CMD 3'h6
`define SEPC_C_RELOAD 3'h7
// reset values
`define SEPC_CMD_RST 3'h0
`define SEPC_ADDR_RST 9'h000
`define SEPC_DATA_RST 8'h00
// valid-image signature at location zero
`define SEPC_SIGNATURE 8'ha5
// timing: system clock, time-out, serial clock divider
`define SEPC_CLK_MHZ 100
`define SEPC_TMO_MS 30
`define SEPC_TMO_CYC (`SEPC_TMO_MS * 1000 * `SEPC_CLK_MHZ)
`define SEPC_SK_HALF 16'h0019
// number of bytes copied out on a load
`define SEPC_LOAD_LEN 9'h020
`endif

// file: rtl/sepc_shift.v
// serial three-wire frame engine: shifts one instruction out, data in
`timescale 1ns/1ps
module sepc_shift (
  input wire clk_in,
  input wire rst_n_in,
  input wire start_in,
  input wire abort_in,
  input wire [4:0] nbits_in,
  input wire [23:0] frame_in,
  input wire wait_rdy_in,
  input wire do_in,
  input wire [15:0] half_in,
  output reg cs_out,
  output reg sk_out,
  output reg di_out,
  output reg [7:0] rdata_out,
  output reg done_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam S_IDLE = 2'd0;
  localparam S_SHIFT = 2'd1;
  localparam S_WAIT = 2'd2;
  localparam S_END = 2'd3;
  reg [1:0] st_r;
  reg [15:0] div_r;
  reg [4:0] cnt_r;
  reg [23:0] sh_r;
  reg wrdy_r;
  wire tick = (div_r == half_in);
  wire [23:0] first_w = frame_in << (5'd24 - nbits_in);

  // one bit per full serial clock; data launched on the falling sk edge so it is settled at the rise
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= S_IDLE;
      div_r <= 16'h0000;
      cnt_r <= 5'h00;
      sh_r <= 24'h000000;
      wrdy_r <= 1'b0;
      cs_out <= 1'b0;
      sk_out <= 1'b0;
      di_out <= 1'b0;
      rdata_out <= 8'h00;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      div_r <= tick ? 16'h0000 : div_r + 16'h0001;
      case (st_r)
        S_IDLE: begin
          sk_out <= 1'b0;
          if (start_in) begin
            st_r <= S_SHIFT;
            cs_out <= 1'b1;
            cnt_r <= nbits_in;
            sh_r <= first_w;
            di_out <= first_w[23];
            wrdy_r <= wait_rdy_in;
            div_r <= 16'h0000;
          end
        end
        S_SHIFT: begin
          if (tick) begin
            if (!sk_out) begin
              sk_out <= 1'b1;
              rdata_out <= {rdata_out[6:0], do_in};
            end else begin
              sk_out <= 1'b0;
              di_out <= sh_r[22];
              sh_r <= {sh_r[22:0], 1'b0};
              cnt_r <= cnt_r - 5'h01;
              if (cnt_r == 5'h01) begin
                st_r <= wrdy_r ? S_WAIT : S_END;
                cs_out <= ~wrdy_r;
                di_out <= 1'b0;
              end
            end
          end
        end
        S_WAIT: begin
          // re-select and poll busy line until the part reports ready
          if (tick) begin
            cs_out <= 1'b1;
            if (cs_out && do_in) begin
              st_r <= S_END;
            end
          end
        end
        S_END: begin
          if (tick) begin
            cs_out <= 1'b0;
            done_out <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        default: st_r <= S_IDLE;
      endcase
      // time-out abort wins over the frame in flight, so select never stays stuck high
      if (abort_in) begin
        st_r <= S_IDLE;
        cs_out <= 1'b0;
        sk_out <= 1'b0;
        di_out <= 1'b0;
      end
    end
  end
endmodule

// file: rtl/sepc_ctrl.v
// serial prom command controller: register port, command sequencer, loader
// How it works
// - writing one to busy runs the selected command; busy holds until done
// - a write with no part attached stays busy until the time-out clears it
// - busy is high from reset until the automatic load has finished or failed
// - three-bit command field at 30:28, reset 000, eight decoded commands
// - read fetches the addressed byte into the data register
// - disable command sends the erase/write disable instruction
// - enable command sends the erase/write enable instruction
// - write location sends the data byte to the addressed location
// - write all sends the data byte to every location
// - erase location erases the addressed location
// - erase all starts a bulk erase
// - reload re-reads the image; fails unless location zero holds a5
// - a failed reload leaves loaded configuration untouched
// - no answer within 30 ms aborts to idle and sets sticky time-out
// - data-loaded flag set on good load, cleared by writing one
// - nine-bit location field at bits 8:0 addresses single-location work
// - data register bits 7:0 hold the byte read or to be written
`timescale 1ns/1ps
`include "sepc_defs.vh"
module sepc_ctrl #(
  parameter TMO_CYCLES = `SEPC_TMO_CYC
) (
  input wire SYS_CLK_IN,
  input wire RESETN_IN,
  input wire [11:0] REG_ADDR_IN,
  input wire [31:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  input wire PROM_DO_IN,
  input wire [4:0] CFG_RADDR_IN,
  output reg [31:0] REG_RDATA_OUT,
  output reg PROM_CS_OUT,
  output reg PROM_SK_OUT,
  output reg PROM_DI_OUT,
  output reg [7:0] CFG_DATA_OUT,
  output reg CFG_VALID_OUT
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg busy_r;
  reg [2:0] cmd_r;
  reg tmo_r;
  reg loaded_r;
  reg [8:0] addr_r;
  reg [7:0] data_r;
  reg cfg_valid_r;
  reg [7:0] cfg_mem [0:31];
  reg [7:0] stage_mem [0:31];

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  localparam Q_IDLE = 3'd0;
  localparam Q_GO = 3'd1;
  localparam Q_RUN = 3'd2;
  localparam Q_NEXT = 3'd3;
  localparam Q_COMMIT = 3'd4;
  localparam Q_DONE = 3'd5;
  reg [2:0] q_r;
  reg load_r;          // current job is a load (power-up or reload)
  reg [8:0] idx_r;     // byte index for load or write-all walk
  reg [31:0] tmo_cnt_r;
  reg [4:0] copy_r;

  // engine
  reg eng_start_r;
  reg [4:0] nbits;
  reg [23:0] frame;
  reg wrdy;
  wire e_cs;
  wire e_sk;
  wire e_di;
  wire [7:0] e_rd;
  wire e_done;
  wire eng_abort;

  // 9-bit byte addressing: start bit, 2-bit opcode, 9-bit address, 8 data
  always @* begin
    nbits = 5'd12;
    wrdy = 1'b0;
    frame = 24'h000000;
    if (load_r) begin
      frame = {4'h0, 3'b110, idx_r, 8'h00};
      nbits = 5'd20;
    end else begin
      case (cmd_r)
        `SEPC_C_READ: begin
          frame = {4'h0, 3'b110, addr_r, 8'h00};
          nbits = 5'd20;
        end
        `SEPC_C_ERASE_WRITE_DISABLE_CMD: frame = {12'h000, 3'b100, 9'h000};
        `SEPC_C_ERASE_WRITE_ENABLE_CMD: frame = {12'h000, 3'b100, 9'h180};
        `SEPC_C_WRITE: begin
          frame = {4'h0, 3'b101, addr_r, data_r};
          nbits = 5'd20;
          wrdy = 1'b1;
        end
        `SEPC_C_WRITE_ALL_CMD: begin
          frame = {4'h0, 3'b101, idx_r, data_r};
          nbits = 5'd20;
          wrdy = 1'b1;
        end
        `SEPC_C_ERASE: begin
          frame = {12'h000, 3'b111, addr_r};
          wrdy = 1'b1;
        end
        `SEPC_C_ERASE_ALL_CMD: begin
          frame = {12'h000, 3'b100, 9'h100};
          wrdy = 1'b1;
        end
        default: frame = {4'h0, 3'b110, idx_r, 8'h00};
      endcase
    end
  end

  // engine: the part's reply timing is its own, the engine only waits
  sepc_shift u_shift (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RESETN_IN),
    .start_in(eng_start_r),
    .abort_in(eng_abort),
    .nbits_in(nbits),
    .frame_in(frame),
    .wait_rdy_in(wrdy),
    .do_in(PROM_DO_IN),
    .half_in(`SEPC_SK_HALF),
    .cs_out(e_cs),
    .sk_out(e_sk),
    .di_out(e_di),
    .rdata_out(e_rd),
    .done_out(e_done)
  );

  // ----------------------------------------
  // register port decode
  // ----------------------------------------
  wire wr_cmd = REG_WR_IN && (REG_ADDR_IN == `SEPC_CMD_OFF);
  wire wr_data = REG_WR_IN && (REG_ADDR_IN == `SEPC_DATA_OFF);
  // commands while busy are ignored; software must wait
  wire go = wr_cmd && REG_WDATA_IN[`SEPC_BUSY_BIT] && !busy_r;
  wire tmo_hit = (tmo_cnt_r == TMO_CYCLES - 1);
  wire last_load = (idx_r == `SEPC_LOAD_LEN - 9'h001);
  wire last_all = (idx_r == 9'h1ff);
  // time-out drops the engine back to idle at the same edge
  assign eng_abort = (q_r == Q_RUN) && tmo_hit;

  // main sequencer: load after reset, then software commands
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      busy_r <= 1'b1;
      load_r <= 1'b1;
      q_r <= Q_GO;
      cmd_r <= `SEPC_CMD_RST;
      addr_r <= `SEPC_ADDR_RST;
      data_r <= `SEPC_DATA_RST;
      tmo_r <= 1'b0;
      loaded_r <= 1'b0;
      idx_r <= 9'h000;
      tmo_cnt_r <= 32'h0;
      eng_start_r <= 1'b0;
    end else begin
      eng_start_r <= 1'b0;
      // software side; command, address and data fields frozen while busy
      if (wr_cmd && !busy_r) begin
        cmd_r <= REG_WDATA_IN[`SEPC_CMD_HI:`SEPC_CMD_LO];
        addr_r <= REG_WDATA_IN[`SEPC_ADDR_HI:`SEPC_ADDR_LO];
      end
      if (wr_data && !busy_r) begin
        data_r <= REG_WDATA_IN[7:0];
      end
      if (wr_cmd && REG_WDATA_IN[`SEPC_TMO_BIT]) begin
        tmo_r <= 1'b0;
      end
      if (wr_cmd && REG_WDATA_IN[`SEPC_LOADED_BIT]) begin
        loaded_r <= 1'b0;
      end
      tmo_cnt_r <= (q_r == Q_RUN) ? tmo_cnt_r + 32'h1 : 32'h0;
      case (q_r)
        Q_IDLE: begin
          if (go) begin
            busy_r <= 1'b1;
            load_r <= (REG_WDATA_IN[`SEPC_CMD_HI:`SEPC_CMD_LO] == `SEPC_C_RELOAD);
            idx_r <= 9'h000;
            q_r <= Q_GO;
          end
        end
        Q_GO: begin
          eng_start_r <= 1'b1;
          q_r <= Q_RUN;
        end
        Q_RUN: begin
          if (tmo_hit) begin
            tmo_r <= 1'b1;
            // busy drops in Q_DONE, a cycle after select is released
            q_r <= Q_DONE;
          end else if (e_done) begin
            q_r <= Q_NEXT;
          end
        end
        Q_NEXT: begin
          if (load_r) begin
            if (idx_r == 9'h000 && e_rd != `SEPC_SIGNATURE) begin
              q_r <= Q_DONE;
            end else if (last_load) begin
              q_r <= Q_COMMIT;
            end else begin
              idx_r <= idx_r + 9'h001;
              q_r <= Q_GO;
            end
          end else if (cmd_r == `SEPC_C_WRITE_ALL_CMD && !last_all) begin
            idx_r <= idx_r + 9'h001;
            q_r <= Q_GO;
          end else begin
            if (cmd_r == `SEPC_C_READ) begin
              data_r <= e_rd;
            end
            q_r <= Q_DONE;
          end
        end
        Q_COMMIT: begin
          if (copy_r == 5'h1f) begin
            loaded_r <= 1'b1;
            q_r <= Q_DONE;
          end
        end
        Q_DONE: begin
          busy_r <= 1'b0;
          load_r <= 1'b0;
          q_r <= Q_IDLE;
        end
        default: q_r <= Q_IDLE;
      endcase
    end
  end

  // staging buffer: live copy changes only after a whole good image
  always @(posedge SYS_CLK_IN) begin
    if (q_r == Q_NEXT && load_r) begin
      stage_mem[idx_r[4:0]] <= e_rd;
    end
  end

  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      copy_r <= 5'h00;
    end else if (q_r == Q_COMMIT) begin
      copy_r <= copy_r + 5'h01;
    end else begin
      copy_r <= 5'h00;
    end
  end

  // live configuration bytes, no reset: undefined until a good load
  always @(posedge SYS_CLK_IN) begin
    if (q_r == Q_COMMIT) begin
      cfg_mem[copy_r] <= stage_mem[copy_r];
    end
  end

  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cfg_valid_r <= 1'b0;
    end else if (q_r == Q_COMMIT && copy_r == 5'h1f) begin
      cfg_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // outputs, all registered
  // ----------------------------------------
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      REG_RDATA_OUT <= 32'h0;
      PROM_CS_OUT <= 1'b0;
      PROM_SK_OUT <= 1'b0;
      PROM_DI_OUT <= 1'b0;
      CFG_DATA_OUT <= 8'h00;
      CFG_VALID_OUT <= 1'b0;
    end else begin
      PROM_CS_OUT <= e_cs;
      PROM_SK_OUT <= e_sk;
      PROM_DI_OUT <= e_di;
      CFG_DATA_OUT <= cfg_valid_r ? cfg_mem[CFG_RADDR_IN] : 8'h00;
      CFG_VALID_OUT <= cfg_valid_r;
      REG_RDATA_OUT <= 32'h0; // unmapped reads give zero
      if (REG_RD_IN && REG_ADDR_IN == `SEPC_CMD_OFF) begin
        REG_RDATA_OUT <= {busy_r, cmd_r, 17'h0, tmo_r, loaded_r, addr_r};
      end else if (REG_RD_IN && REG_ADDR_IN == `SEPC_DATA_OFF) begin
        REG_RDATA_OUT <= {24'h0, data_r};
      end
    end
  end
endmodule

// file: tb/sepc_ctrl_monitor.sv
// port-level assertions for the serial prom controller
`timescale 1ns/1ps
module sepc_ctrl_monitor #(
  parameter TMO_CYCLES = 3000000
) (
  input wire SYS_CLK_IN,
  input wire RESETN_IN,
  input wire [11:0] REG_ADDR_IN,
  input wire [31:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  input wire PROM_DO_IN,
  input wire [4:0] CFG_RADDR_IN,
  input wire [31:0] REG_RDATA_OUT,
  input wire PROM_CS_OUT,
  input wire PROM_SK_OUT,
  input wire PROM_DI_OUT,
  input wire [7:0] CFG_DATA_OUT,
  input wire CFG_VALID_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  reg [5:0] sk_hi_r;
  reg first_r;
  reg idle_r;
  // serial clock high time, first bit of a frame, inverse of the last busy value polled
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sk_hi_r <= 6'h00;
      first_r <= 1'b0;
      idle_r <= 1'b0;
    end else begin
      sk_hi_r <= PROM_SK_OUT ? sk_hi_r + 6'h01 : 6'h00;
      if ($rose(PROM_CS_OUT))
        first_r <= 1'b1;
      else if (PROM_SK_OUT)
        first_r <= 1'b0;
      if (REG_WR_IN && REG_ADDR_IN == 12'h030 && REG_WDATA_IN[31])
        idle_r <= 1'b0;
      else if ($past(REG_RD_IN) && $past(REG_ADDR_IN) == 12'h030)
        idle_r <= ~REG_RDATA_OUT[31];
    end
  end
  chk_busy_frame: assert property (
    $past(REG_RD_IN) && $past(REG_ADDR_IN) == 12'h030 && $past(PROM_CS_OUT) |-> REG_RDATA_OUT[31])
    else $error("busy low during a frame");
  chk_cmd_start: assert property (
    REG_WR_IN && REG_ADDR_IN == 12'h030 && REG_WDATA_IN[31] && idle_r |-> ##[1:8] PROM_CS_OUT)
    else $error("command did not start a frame");
  chk_cmd_rsvd: assert property (
    $past(REG_RD_IN) && $past(REG_ADDR_IN) == 12'h030 |-> REG_RDATA_OUT[27:11] == 17'h0)
    else $error("reserved command bits set");
  chk_data_rsvd: assert property (
    $past(REG_RD_IN) && $past(REG_ADDR_IN) == 12'h034 |-> REG_RDATA_OUT[31:8] == 24'h0)
    else $error("reserved data bits set");
  chk_valid_sticky: assert property (CFG_VALID_OUT |=> CFG_VALID_OUT)
    else $error("loaded config dropped");
  chk_sk_half: assert property ($fell(PROM_SK_OUT) |-> sk_hi_r == 6'd26)
    else $error("serial clock high time wrong");
  chk_sk_frame: assert property (PROM_SK_OUT |-> PROM_CS_OUT)
    else $error("serial clock outside frame");
  chk_start_bit: assert property ($rose(PROM_SK_OUT) && first_r |-> PROM_DI_OUT)
    else $error("frame start bit not one");
  chk_di_setup: assert property ($rose(PROM_SK_OUT) |-> $stable(PROM_DI_OUT))
    else $error("data changed on clock rise");
endmodule

// file: tb/sepc_prom_model.sv
// behavioural three-wire serial prom on the controller's far side
`timescale 1ns/1ps
module sepc_prom_model (
  input wire cs_in,
  input wire sk_in,
  input wire di_in,
  input wire present_in,
  input wire [15:0] busy_ns_in,
  output wire do_out
);
  reg [7:0] mem [0:511];
  reg wen_r;
  reg do_r;
  reg pend_r;
  reg [4:0] cnt_r;
  reg [11:0] hdr_r;
  reg [7:0] dat_r;
  integer i;
  // missing part leaves the line pulled low, so writes never see ready
  assign do_out = present_in ? do_r : 1'b0;
  // powers up write-disabled holding a valid image
  initial begin
    wen_r = 1'b0;
    do_r = 1'b1;
    pend_r = 1'b0;
    cnt_r = 5'h00;
    for (i = 0; i < 512; i = i + 1) mem[i] = i[7:0] ^ 8'h3c;
    mem[0] = 8'ha5;
  end
  // shift in instruction and data on rising serial clock
  always @(posedge sk_in) if (cs_in) begin
    cnt_r = cnt_r + 5'h01;
    if (cnt_r <= 5'd12)
      hdr_r = {hdr_r[10:0], di_in};
    else if (hdr_r[10:9] != 2'b10)
      dat_r = {dat_r[6:0], di_in};
    if (cnt_r == 5'd12) begin
      if (hdr_r[10:9] == 2'b10) dat_r = mem[hdr_r[8:0]];
      if (hdr_r[10:7] == 4'b0011) wen_r = 1'b1;
      if (hdr_r[10:7] == 4'b0000) wen_r = 1'b0;
      if (wen_r && hdr_r[10:9] == 2'b11) mem[hdr_r[8:0]] = 8'hff;
      for (i = 0; i < 512; i = i + 1) if (wen_r && hdr_r[10:7] == 4'b0010) mem[i] = 8'hff;
    end
    if (cnt_r == 5'd20 && wen_r) begin
      if (hdr_r[10:9] == 2'b01) mem[hdr_r[8:0]] = dat_r;
      for (i = 0; i < 512; i = i + 1) if (hdr_r[10:7] == 4'b0001) mem[i] = dat_r;
    end
    pend_r = wen_r && cnt_r >= 5'd12 && hdr_r[10:9] != 2'b10
      && !(hdr_r[10:9] == 2'b00 && hdr_r[8] == hdr_r[7]);
  end
  // read data change on the falling edge, ready for the next rise
  always @(negedge sk_in)
    if (cs_in && hdr_r[10:9] == 2'b10 && cnt_r >= 5'd12 && cnt_r < 5'd20)
      do_r = dat_r[5'd19 - cnt_r];
  always @(posedge cs_in) cnt_r = 5'h00;
  // write cycle: busy low for a while, then released to the pull-up
  always @(negedge cs_in) begin
    do_r = ~pend_r;
    pend_r = 1'b0;
    #(busy_ns_in) do_r = 1'b1;
  end
endmodule

// file: tb/tb.sv
// register-level testbench for the serial prom controller
`timescale 1ns/1ps
module tb;
  localparam integer TMO = 3000;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [11:0] addr = 12'h000;
  reg [31:0] wdat = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [4:0] cfg_a = 5'h01;
  reg present = 1'b1;
  reg [15:0] bsy = 16'd2000;
  wire [31:0] rdat;
  wire cs, sk, di, dout, cfg_v;
  wire [7:0] cfg_d;
  reg [31:0] rv;
  integer errors = 0;
  integer cmp_count = 0;
  integer n;
  always #5 clk = ~clk;
  sepc_ctrl #(.TMO_CYCLES(TMO)) DUT (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdat), .REG_WR_IN(wr), .REG_RD_IN(rd), .PROM_DO_IN(dout), .CFG_RADDR_IN(cfg_a),
    .REG_RDATA_OUT(rdat), .PROM_CS_OUT(cs), .PROM_SK_OUT(sk), .PROM_DI_OUT(di),
    .CFG_DATA_OUT(cfg_d), .CFG_VALID_OUT(cfg_v));
  sepc_prom_model PROM (.cs_in(cs), .sk_in(sk), .di_in(di), .present_in(present),
    .busy_ns_in(bsy), .do_out(dout));
  function [7:0] img(input [8:0] a);
    img = (a == 9'h0) ? 8'ha5 : a[7:0] ^ 8'h3c;
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("mismatches %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // one-cycle strobe, then an idle cycle so strobes never retrigger
  task wr_reg(input [11:0] a, input [31:0] d);
    begin
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd_reg(input [11:0] a);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdat;
      @(posedge clk);
    end
  endtask
  // poll busy, bounded; nothing new is issued before it clears
  task wait_idle;
    begin
      n = 0;
      rd_reg(12'h030);
      while (rv[31] !== 1'b0 && n < 40000) begin
        rd_reg(12'h030);
        n = n + 1;
      end
      if (n >= 40000) check(32'h1, 32'h0);
    end
  endtask
  task cmd(input [2:0] c, input [8:0] loc);
    begin
      wr_reg(12'h030, {1'b1, c, 19'h0, loc});
      wait_idle;
    end
  endtask
  task rd_loc(input [8:0] loc, input [7:0] exp);
    begin
      cmd(3'h0, loc);
      rd_reg(12'h034);
      check(rv, {24'h0, exp});
    end
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(12'h030);
    check(rv[31], 1'b1);
    wait_idle;
    check(rv, 32'h0000_0200);
    check(cfg_v, 1'b1);
    check(cfg_d, img(9'h001));
    wr_reg(12'h030, 32'h0000_0200);
    rd_reg(12'h030);
    check(rv, 32'h0);
    rd_reg(12'h038);
    check(rv, 32'h0);
    rd_loc(9'h1a3, img(9'h1a3));
    wr_reg(12'h034, 32'hffff_ff77);
    rd_reg(12'h034);
    check(rv, 32'h77);
    cmd(3'h3, 9'h1a3);
    rd_loc(9'h1a3, img(9'h1a3));
    cmd(3'h2, 9'h0);
    wr_reg(12'h034, 32'h77);
    cmd(3'h3, 9'h1a3);
    rd_loc(9'h1a3, 8'h77);
    bsy <= 16'd0;
    cmd(3'h5, 9'h1a3);
    rd_loc(9'h1a3, 8'hff);
    cmd(3'h1, 9'h0);
    wr_reg(12'h034, 32'h11);
    cmd(3'h3, 9'h1a3);
    rd_loc(9'h1a3, 8'hff);
    cmd(3'h2, 9'h0);
    wr_reg(12'h034, 32'h5a);
    cmd(3'h3, 9'h0);
    cmd(3'h7, 9'h0);
    check(rv, 32'h7000_0000);
    check(cfg_d, img(9'h001));
    check(cfg_v, 1'b1);
    cmd(3'h6, 9'h0);
    rd_loc(9'h0aa, 8'hff);
    present <= 1'b0;
    cmd(3'h4, 9'h0);
    check(n * 2 + 20 >= TMO, 1'b1);
    check(n * 2 <= TMO + 20, 1'b1);
    check(rv[10], 1'b1);
    wr_reg(12'h030, 32'h0000_0400);
    rd_reg(12'h030);
    check(rv[10], 1'b0);
    report_and_stop;
  end
  // watchdog well beyond the expected run length
  initial begin
    #900000;
    errors = errors + 1;
    report_and_stop;
  end
endmodule
bind sepc_ctrl sepc_ctrl_monitor #(.TMO_CYCLES(TMO_CYCLES)) MON (.SYS_CLK_IN(SYS_CLK_IN),
  .RESETN_IN(RESETN_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .PROM_DO_IN(PROM_DO_IN),
  .CFG_RADDR_IN(CFG_RADDR_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .PROM_CS_OUT(PROM_CS_OUT),
  .PROM_SK_OUT(PROM_SK_OUT), .PROM_DI_OUT(PROM_DI_OUT), .CFG_DATA_OUT(CFG_DATA_OUT),
  .CFG_VALID_OUT(CFG_VALID_OUT));
